// File: core/scd_spi_command_decoder.sv
// SPI command decoder: mode commands, reads, two-step writes and answer selection.
// Assumes permission inputs answer combinationally for the address on permitAddr,
// and that register read data is valid whenever chip select falls.
//
// Overview of operation
// - Word 1880 enters configuration mode from default or error mode, else error.
// - Word 1140 enters verification mode from configuration mode, else error.
// - Word 1220 leaves configuration for configured mode, else error.
// - Word 1410 does nothing in any mode but is still validity checked.
// - Mode, no-operation and write commands answer with the primary status.
// - Read word is address<<7 | 002A | parity; answer is that register.
// - In active and weak active modes reads outside permitted set are errors.
// - Write-high 4400 | data<<1 | parity loads only the buffer upper byte.
// - Write-low fills low byte, writes whole buffer to register, clears buffer.
// - Write-low to an address not permitted in this mode is an error.
// - Write-low word is A000 | address<<7 | six data bits<<1 | parity.
// - Words carry odd parity in bit 0; fixed commands always need it.
// - Error drops the request, sets error flag, answers with invalid bit.
// - Answer to a request goes out in the following transfer.
`timescale 1ns/1ps
module scd_spi_command_decoder (
   input  wire logic               sys_clk,
   input  wire logic               arst_n,
   input  wire logic               spiCsN,
   input  wire logic               spiSclk,
   input  wire logic               spiMosi,
   output logic                    spiMiso,
   output logic                    spiMisoOe,
   input  wire logic               parityCheckEnable,
   input  wire logic [15:0]        primaryStatus,
   output logic [4:0]              permitAddr,
   input  wire logic               readPermit,
   input  wire logic               writePermit,
   output logic [4:0]              regReadAddr,
   input  wire logic [15:0]        regReadData,
   output logic                    regWriteValid,
   output logic [4:0]              regWriteAddr,
   output logic [15:0]             regWriteData,
   input  wire logic               modeSetValid,
   input  wire scd_pkg::scd_mode_e modeSetTo,
   output scd_pkg::scd_mode_e      opMode,
   output logic                    spiErrorFlag,
   output logic                    spiErrorPulse,
   input  wire logic               spiErrorClear
);

   // ---------------------------------------------------------------
   // Front end
   // ---------------------------------------------------------------
   logic [15:0] rxWord, answerWord, answerPayload;
   logic        frameDone, frameOk;
   scd_pkg::scd_answer_e answerSel;

   scd_spi_frontend u_frontend (
      .sys_clk    (sys_clk),
      .arst_n     (arst_n),
      .spiCsN     (spiCsN),
      .spiSclk    (spiSclk),
      .spiMosi    (spiMosi),
      .answerWord (answerWord),
      .spiMiso    (spiMiso),
      .spiMisoOe  (spiMisoOe),
      .rxWord     (rxWord),
      .frameDone  (frameDone),
      .frameOk    (frameOk)
   );

   assign permitAddr = rxWord[scd_pkg::ADDR_MSB:scd_pkg::ADDR_LSB];

   // ---------------------------------------------------------------
   // Answer word
   // ---------------------------------------------------------------
   always_comb begin
      unique case (answerSel)
         scd_pkg::ANS_READ:  answerPayload = regReadData;
         scd_pkg::ANS_ERROR: answerPayload = primaryStatus | scd_pkg::INVALID_MSG_MASK;
         default:            answerPayload = primaryStatus;
      endcase
      // Outgoing parity is always generated, whatever the check setting
      answerWord = {answerPayload[15:1], scd_pkg::scd_parity(answerPayload[15:1])};
   end

   // ---------------------------------------------------------------
   // Command decode
   // ---------------------------------------------------------------
   logic        isRead, isWriteHigh, isWriteLow, parityFail, restricted, errNow;
   logic [15:0] writeBuf, next_writeBuf, next_regWriteData;
   logic [4:0]  next_regReadAddr, next_regWriteAddr;
   logic        next_regWriteValid, next_spiErrorFlag;
   scd_pkg::scd_mode_e   next_opMode;
   scd_pkg::scd_answer_e next_answerSel;

   assign isRead      = scd_pkg::scd_match(rxWord, scd_pkg::READ_MASK, scd_pkg::READ_MATCH);
   assign isWriteHigh = scd_pkg::scd_match(rxWord, scd_pkg::WRH_MASK, scd_pkg::WRH_MATCH);
   assign isWriteLow  = scd_pkg::scd_match(rxWord, scd_pkg::WRL_MASK, scd_pkg::WRL_MATCH);
   assign parityFail  = parityCheckEnable & ~(^rxWord);
   assign restricted  = (opMode == scd_pkg::MODE_ACTIVE) || (opMode == scd_pkg::MODE_WEAK_ACTIVE);

   always_comb begin
      next_opMode        = opMode;
      next_answerSel     = answerSel;
      next_writeBuf      = writeBuf;
      next_regReadAddr   = regReadAddr;
      next_regWriteAddr  = regWriteAddr;
      next_regWriteData  = regWriteData;
      next_regWriteValid = 1'b0;
      errNow             = 1'b0;
      if (frameDone) begin
         // Fixed words compare all 16 bits, so their parity is checked even when disabled
         if (!frameOk || parityFail) begin
            errNow = 1'b1;
         end else if (rxWord == scd_pkg::CMD_ENTER_CONFIG) begin
            if (opMode == scd_pkg::MODE_DEFAULT || opMode == scd_pkg::MODE_ERROR) begin
               next_opMode = scd_pkg::MODE_CONFIG;
            end else begin
               errNow = 1'b1;
            end
         end else if (rxWord == scd_pkg::CMD_ENTER_VERIFY) begin
            if (opMode == scd_pkg::MODE_CONFIG) begin
               next_opMode = scd_pkg::MODE_VERIFY;
            end else begin
               errNow = 1'b1;
            end
         end else if (rxWord == scd_pkg::CMD_LEAVE_CONFIG) begin
            if (opMode == scd_pkg::MODE_CONFIG) begin
               next_opMode = scd_pkg::MODE_CONFIGURED;
            end else begin
               errNow = 1'b1;
            end
         end else if (rxWord == scd_pkg::CMD_NOP) begin
            errNow = 1'b0;
         end else if (isRead) begin
            if (restricted && !readPermit) begin
               errNow = 1'b1;
            end else begin
               next_regReadAddr = rxWord[scd_pkg::ADDR_MSB:scd_pkg::ADDR_LSB];
            end
         end else if (isWriteHigh) begin
            next_writeBuf[15:8] = rxWord[scd_pkg::WRH_DATA_MSB:scd_pkg::DATA_LSB];
         end else if (isWriteLow) begin
            if (!writePermit) begin
               errNow = 1'b1;
            end else begin
               next_regWriteAddr  = rxWord[scd_pkg::ADDR_MSB:scd_pkg::ADDR_LSB];
               next_regWriteData  = {writeBuf[15:8], rxWord[scd_pkg::WRL_DATA_MSB:scd_pkg::DATA_LSB],
                                     scd_pkg::WRL_LOW_PAD};
               next_regWriteValid = 1'b1;
               next_writeBuf      = scd_pkg::WBUF_RESET;
            end
         end else begin
            errNow = 1'b1;
         end
         // Errored requests leave mode and buffers untouched and answer with the invalid bit
         if (errNow) begin
            next_answerSel = scd_pkg::ANS_ERROR;
         end else if (isRead) begin
            next_answerSel = scd_pkg::ANS_READ;
         end else begin
            next_answerSel = scd_pkg::ANS_STATUS;
         end
      end
      // The outer mode machine has the last word over mode
      if (modeSetValid) begin
         next_opMode = modeSetTo;
      end
      // A new error in the clearing cycle keeps the flag set
      next_spiErrorFlag = errNow | (spiErrorFlag & ~spiErrorClear);
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         opMode        <= scd_pkg::MODE_DEFAULT;
         answerSel     <= scd_pkg::ANS_STATUS;
         writeBuf      <= scd_pkg::WBUF_RESET;
         regReadAddr   <= scd_pkg::ADDR_RESET;
         regWriteAddr  <= scd_pkg::ADDR_RESET;
         regWriteData  <= scd_pkg::WBUF_RESET;
         regWriteValid <= 1'b0;
         spiErrorFlag  <= 1'b0;
         spiErrorPulse <= 1'b0;
      end else begin
         opMode        <= next_opMode;
         answerSel     <= next_answerSel;
         writeBuf      <= next_writeBuf;
         regReadAddr   <= next_regReadAddr;
         regWriteAddr  <= next_regWriteAddr;
         regWriteData  <= next_regWriteData;
         regWriteValid <= next_regWriteValid;
         spiErrorFlag  <= next_spiErrorFlag;
         spiErrorPulse <= errNow;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   logic goodFrame;
   assign goodFrame = frameDone && frameOk && !parityFail && !modeSetValid;

   property p_enter_config;
      goodFrame && rxWord == scd_pkg::CMD_ENTER_CONFIG &&
      (opMode == scd_pkg::MODE_DEFAULT || opMode == scd_pkg::MODE_ERROR)
      |=> opMode == scd_pkg::MODE_CONFIG && answerSel == scd_pkg::ANS_STATUS;
   endproperty
   a_enter_config: assert property (p_enter_config) else $error("config entry failed");

   property p_enter_config_bad;
      goodFrame && rxWord == scd_pkg::CMD_ENTER_CONFIG &&
      !(opMode == scd_pkg::MODE_DEFAULT || opMode == scd_pkg::MODE_ERROR)
      |=> $stable(opMode) && spiErrorFlag && spiErrorPulse && answerSel == scd_pkg::ANS_ERROR;
   endproperty
   a_enter_config_bad: assert property (p_enter_config_bad) else $error("bad config entry not flagged");

   property p_enter_verify;
      goodFrame && rxWord == scd_pkg::CMD_ENTER_VERIFY
      |=> (($past(opMode) == scd_pkg::MODE_CONFIG) ? (opMode == scd_pkg::MODE_VERIFY)
                                                   : (spiErrorFlag && $stable(opMode)));
   endproperty
   a_enter_verify: assert property (p_enter_verify) else $error("verify entry wrong");

   property p_leave_config;
      goodFrame && rxWord == scd_pkg::CMD_LEAVE_CONFIG
      |=> (($past(opMode) == scd_pkg::MODE_CONFIG) ? (opMode == scd_pkg::MODE_CONFIGURED)
                                                   : (spiErrorFlag && $stable(opMode)));
   endproperty
   a_leave_config: assert property (p_leave_config) else $error("config exit wrong");

   property p_nop;
      goodFrame && rxWord == scd_pkg::CMD_NOP
      |=> $stable(opMode) && $stable(writeBuf) && !spiErrorPulse && answerSel == scd_pkg::ANS_STATUS;
   endproperty
   a_nop: assert property (p_nop) else $error("nop had an effect");

   property p_read;
      goodFrame && isRead && !(restricted && !readPermit)
      |=> answerSel == scd_pkg::ANS_READ && regReadAddr == $past(rxWord[11:7]);
   endproperty
   a_read: assert property (p_read) else $error("read not answered");

   property p_read_restrict;
      goodFrame && isRead && restricted && !readPermit
      |=> spiErrorFlag && answerSel == scd_pkg::ANS_ERROR && $stable(regReadAddr);
   endproperty
   a_read_restrict: assert property (p_read_restrict) else $error("restricted read accepted");

   property p_write_high;
      goodFrame && isWriteHigh
      |=> writeBuf[15:8] == $past(rxWord[8:1]) && !regWriteValid && $stable(opMode);
   endproperty
   a_write_high: assert property (p_write_high) else $error("write-high not buffered");

   property p_write_low;
      goodFrame && isWriteLow && writePermit
      |=> regWriteValid && regWriteData == {$past(writeBuf[15:8]), $past(rxWord[6:1]), 2'h0} &&
          writeBuf == 16'h0000 ##1 !regWriteValid;
   endproperty
   a_write_low: assert property (p_write_low) else $error("write-low wrong");

   property p_write_refused;
      goodFrame && isWriteLow && !writePermit |=> !regWriteValid && spiErrorFlag && $stable(writeBuf);
   endproperty
   a_write_refused: assert property (p_write_refused) else $error("forbidden write done");

   property p_answer_parity;
      ^answerWord;
   endproperty
   a_answer_parity: assert property (p_answer_parity) else $error("answer parity even");

   property p_error_set_wins;
      errNow && spiErrorClear |=> spiErrorFlag;
   endproperty
   a_error_set_wins: assert property (p_error_set_wins) else $error("error lost on clear");

   property p_unknown;
      goodFrame && !isRead && !isWriteHigh && !isWriteLow && rxWord != scd_pkg::CMD_ENTER_CONFIG &&
      rxWord != scd_pkg::CMD_ENTER_VERIFY && rxWord != scd_pkg::CMD_LEAVE_CONFIG && rxWord != scd_pkg::CMD_NOP
      |=> spiErrorPulse && answerSel == scd_pkg::ANS_ERROR;
   endproperty
   a_unknown: assert property (p_unknown) else $error("unknown word accepted");

   property p_error_clear;
      !errNow && spiErrorClear |=> !spiErrorFlag;
   endproperty
   a_error_clear: assert property (p_error_clear) else $error("error flag not cleared");

   property p_error_pulse;
      spiErrorPulse |=> !spiErrorPulse;
   endproperty
   a_error_pulse: assert property (p_error_pulse) else $error("error pulse too long");

   property p_write_source;
      regWriteValid |-> $past(frameDone) && $past(isWriteLow) && $past(writePermit);
   endproperty
   a_write_source: assert property (p_write_source) else $error("write without write-low");

   property p_frame_error;
      frameDone && !frameOk && !modeSetValid
      |=> spiErrorPulse && $stable(opMode) && answerSel == scd_pkg::ANS_ERROR;
   endproperty
   a_frame_error: assert property (p_frame_error) else $error("bad frame accepted");

   c_config_then_leave: cover property (goodFrame && rxWord == scd_pkg::CMD_ENTER_CONFIG
                                        ##[1:1000] goodFrame && rxWord == scd_pkg::CMD_LEAVE_CONFIG);
   c_two_step_write: cover property (goodFrame && isWriteHigh ##[1:1000] regWriteValid);
   c_read_answer: cover property (goodFrame && isRead ##[1:1000] spiMisoOe);
   c_error_answer: cover property (spiErrorPulse ##[1:1000] spiMisoOe);

endmodule : scd_spi_command_decoder

// File: core/scd_pkg.sv
// Constants, encodings and helpers shared by the SPI command decoder.
// Assumes 16-bit request and answer words with odd parity in bit 0.
package scd_pkg;

   // ---------------------------------------------------------------
   // Fixed command words and field layouts
   // ---------------------------------------------------------------
   localparam logic [15:0] CMD_ENTER_CONFIG = 16'h1880;
   localparam logic [15:0] CMD_ENTER_VERIFY = 16'h1140;
   localparam logic [15:0] CMD_LEAVE_CONFIG = 16'h1220;
   localparam logic [15:0] CMD_NOP          = 16'h1410;
   localparam logic [15:0] READ_MASK        = 16'hf07e;
   localparam logic [15:0] READ_MATCH       = 16'h002a;
   localparam logic [15:0] WRH_MASK         = 16'hfe00;
   localparam logic [15:0] WRH_MATCH        = 16'h4400;
   localparam logic [15:0] WRL_MASK         = 16'hf000;
   localparam logic [15:0] WRL_MATCH        = 16'ha000;
   localparam int          ADDR_LSB         = 7;
   localparam int          ADDR_MSB         = 11;
   localparam int          DATA_LSB         = 1;
   localparam int          WRH_DATA_MSB     = 8;
   localparam int          WRL_DATA_MSB     = 6;
   localparam int          WORD_MSB         = 15;
   localparam logic [15:0] INVALID_MSG_MASK = 16'h8000;
   localparam logic [15:0] WBUF_RESET       = 16'h0000;
   localparam logic [4:0]  ADDR_RESET       = 5'h00;
   localparam logic [1:0]  WRL_LOW_PAD      = 2'h0;

   // ---------------------------------------------------------------
   // Frame edge counting
   // ---------------------------------------------------------------
   localparam int          CNT_W            = 8;
   localparam logic [7:0]  CNT_MAX          = 8'hff;
   localparam logic [7:0]  CNT_ZERO         = 8'h00;
   localparam logic [3:0]  WORD_PHASE_ZERO  = 4'h0;

   // ---------------------------------------------------------------
   // Operating modes and answer sources
   // ---------------------------------------------------------------
   typedef enum logic [6:0] {
      MODE_DEFAULT     = 7'h01,
      MODE_ERROR       = 7'h02,
      MODE_CONFIG      = 7'h04,
      MODE_CONFIGURED  = 7'h08,
      MODE_ACTIVE      = 7'h10,
      MODE_VERIFY      = 7'h20,
      MODE_WEAK_ACTIVE = 7'h40
   } scd_mode_e;

   typedef enum logic [2:0] {
      ANS_STATUS = 3'h1,
      ANS_READ   = 3'h2,
      ANS_ERROR  = 3'h4
   } scd_answer_e;

   // Odd parity bit over a 15-bit payload
   function automatic logic scd_parity(input logic [14:0] payload);
      return ~(^payload);
   endfunction : scd_parity

   // Masked match of a received word against a command pattern
   function automatic logic scd_match(input logic [15:0] w, input logic [15:0] mask, input logic [15:0] value);
      return (w & mask) == value;
   endfunction : scd_match

endpackage : scd_pkg

// File: core/scd_spi_frontend.sv
// SPI slave front end: pin synchronisers, edge finding, shift register, frame check.
// Assumes sys_clk is far faster than the SPI clock; pins are asynchronous to sys_clk.
`timescale 1ns/1ps
module scd_spi_frontend (
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   input  wire logic        spiCsN,
   input  wire logic        spiSclk,
   input  wire logic        spiMosi,
   input  wire logic [15:0] answerWord,
   output logic             spiMiso,
   output logic             spiMisoOe,
   output logic [15:0]      rxWord,
   output logic             frameDone,
   output logic             frameOk
);

   // ---------------------------------------------------------------
   // Synchronisers
   // ---------------------------------------------------------------
   logic csMeta, csSync, csLast;
   logic sclkMeta, sclkSync, sclkLast;
   logic mosiMeta, mosiSync;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         csMeta   <= 1'b1;
         csSync   <= 1'b1;
         csLast   <= 1'b1;
         sclkMeta <= 1'b0;
         sclkSync <= 1'b0;
         sclkLast <= 1'b0;
         mosiMeta <= 1'b0;
         mosiSync <= 1'b0;
      end else begin
         csMeta   <= spiCsN;
         csSync   <= csMeta;
         csLast   <= csSync;
         sclkMeta <= spiSclk;
         sclkSync <= sclkMeta;
         sclkLast <= sclkSync;
         mosiMeta <= spiMosi;
         mosiSync <= mosiMeta;
      end
   end

   // ---------------------------------------------------------------
   // Shift register and edge counters
   // ---------------------------------------------------------------
   // Counters saturate so an overlong frame can never wrap into a legal count
   function automatic logic [scd_pkg::CNT_W-1:0] satInc(input logic [scd_pkg::CNT_W-1:0] c);
      return (c == scd_pkg::CNT_MAX) ? c : c + 1'b1;
   endfunction : satInc

   logic                      selected, csFall, csRise, sclkRise, sclkFall;
   logic [scd_pkg::CNT_W-1:0] riseCnt, fallCnt, next_riseCnt, next_fallCnt;
   logic [15:0]               next_rxWord;
   logic                      next_spiMiso, next_frameOk;

   assign selected = ~csSync;
   assign csFall   = csLast & ~csSync;
   assign csRise   = ~csLast & csSync;
   assign sclkRise = selected & ~sclkLast & sclkSync;
   assign sclkFall = selected & sclkLast & ~sclkSync;

   always_comb begin
      next_rxWord  = rxWord;
      next_spiMiso = spiMiso;
      next_riseCnt = riseCnt;
      next_fallCnt = fallCnt;
      next_frameOk = (riseCnt == fallCnt) && (riseCnt[3:0] == scd_pkg::WORD_PHASE_ZERO) &&
                     (riseCnt != scd_pkg::CNT_ZERO) && (riseCnt != scd_pkg::CNT_MAX);
      if (csFall) begin
         // Answer of the previous request is captured at select time
         next_rxWord  = answerWord;
         next_spiMiso = answerWord[scd_pkg::WORD_MSB];
         next_riseCnt = scd_pkg::CNT_ZERO;
         next_fallCnt = scd_pkg::CNT_ZERO;
      end else begin
         if (sclkRise) begin
            next_spiMiso = rxWord[scd_pkg::WORD_MSB];
            next_riseCnt = satInc(riseCnt);
         end
         // Bits shift through, so in a chain the last 16 received are ours
         if (sclkFall) begin
            next_rxWord  = {rxWord[14:0], mosiSync};
            next_fallCnt = satInc(fallCnt);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rxWord    <= scd_pkg::WBUF_RESET;
         spiMiso   <= 1'b0;
         spiMisoOe <= 1'b0;
         riseCnt   <= scd_pkg::CNT_ZERO;
         fallCnt   <= scd_pkg::CNT_ZERO;
         frameDone <= 1'b0;
         frameOk   <= 1'b0;
      end else begin
         rxWord    <= next_rxWord;
         spiMiso   <= next_spiMiso;
         spiMisoOe <= selected;
         riseCnt   <= next_riseCnt;
         fallCnt   <= next_fallCnt;
         frameDone <= csRise;
         frameOk   <= next_frameOk;
      end
   end

endmodule : scd_spi_frontend

// File: tb/scd_spi_master.sv
// SPI master model: one transfer of up to 16 bits per call, MSB first, clock idle low.
// Assumes the caller starts just after a sys_clk edge; SCLK half period is 80 ns.
`timescale 1ns/1ps
module scd_spi_master (
   output logic      csN,
   output logic      sclk,
   output logic      mosi,
   input  wire logic miso,
   input  wire logic misoOe
);
   // ------------------------------------------------------------
   // Transfer
   // ------------------------------------------------------------
   initial begin
      csN = 1'h1;
      sclk = 1'h0;
      mosi = 1'h0;
   end

   // Words come in whole, parity already in bit 0; fewer than 16 bits make a bad frame
   task automatic xfer(input logic [15:0] w, input int nb, output logic [15:0] a);
      csN = 1'h0;
      #80;
      for (int i = nb - 1; i >= 0; i--) begin
         #40 mosi = w[i];
         #40 sclk = 1'h1;
         // The device moves its output on the rise, so read it just before the fall
         #80 a[i] = misoOe ? miso : 1'hx; // Answer of the previous request
         sclk = 1'h0;
      end
      #80 csN = 1'h1;
      mosi = ~mosi; // Released line shows no stale bit
      #80;
   endtask : xfer
endmodule : scd_spi_master

// File: tb/tb.sv
// Bench for the SPI command decoder: table of requests, then mode, parity and reset cases.
// Assumes decode effects land within the 80 ns gap after chip select rises.
`timescale 1ns/1ps
`define CHK(g, x) begin checked++; if ((g) !== (x)) begin errCount++; $display("[FAIL] %0t got %h exp %h", $time, g, x); end end
module tb;
   // ------------------------------------------------------------
   // Signals and instances
   // ------------------------------------------------------------
   typedef struct {logic [15:0] q; logic [6:0] m; logic e; logic [15:0] a; logic [20:0] d;} scd_row_s;
   logic               sys_clk = 1'h0, arst_n = 1'h0, parEn = 1'h1, modeSetValid = 1'h0, spiErrorClear = 1'h0;
   logic               csN, sclk, mosi, miso, misoOe, readPermit, writePermit, regWriteValid, spiErrorFlag;
   logic               spiErrorPulse;
   logic [4:0]         permitAddr, regReadAddr, regWriteAddr;
   logic [15:0]        regReadData, regWriteData, gotShort, expAns = 16'h3456, st = 16'h3456;
   logic [20:0]        lastW = 21'h0;
   scd_pkg::scd_mode_e opMode, modeSetTo = scd_pkg::MODE_DEFAULT;
   int                 errCount = 0, checked = 0, pulseCnt = 0, nPulse = 0;
   scd_row_s rows [13] = '{'{16'h1410, 7'h01, 1'h0, 16'h3456, 21'h0}, '{16'h1140, 7'h01, 1'h1, 16'hb456, 21'h0},
      '{16'h1220, 7'h01, 1'h1, 16'hb456, 21'h0}, '{16'h1880, 7'h04, 1'h0, 16'h3456, 21'h0},
      '{16'h1880, 7'h04, 1'h1, 16'hb456, 21'h0}, '{16'h454a, 7'h04, 1'h0, 16'h3456, 21'h0},
      '{16'ha1d6, 7'h04, 1'h0, 16'h3456, 21'h03a5ac}, '{16'ha2a2, 7'h04, 1'h0, 16'h3456, 21'h050044},
      '{16'ha900, 7'h04, 1'h1, 16'hb456, 21'h050044}, '{16'h0aaa, 7'h04, 1'h0, 16'hb53c, 21'h050044},
      '{16'h0000, 7'h04, 1'h1, 16'hb456, 21'h050044}, '{16'h1220, 7'h08, 1'h0, 16'h3456, 21'h050044},
      '{16'h1140, 7'h08, 1'h1, 16'hb456, 21'h050044}};
   assign writePermit = permitAddr < 5'h10;
   assign readPermit = permitAddr < 5'h08;
   assign regReadData = {3'h5, regReadAddr, 8'h3c};
   always #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (spiErrorPulse === 1'h1) pulseCnt++;
      if (regWriteValid === 1'h1) lastW <= {regWriteAddr, regWriteData};
   end
   scd_spi_master scd_spi_master_inst (.csN, .sclk, .mosi, .miso, .misoOe);
   scd_spi_command_decoder scd_spi_command_decoder_inst (.sys_clk, .arst_n, .spiCsN(csN), .spiSclk(sclk),
      .spiMosi(mosi), .spiMiso(miso), .spiMisoOe(misoOe), .parityCheckEnable(parEn), .primaryStatus(st),
      .permitAddr, .readPermit, .writePermit, .regReadAddr, .regReadData, .regWriteValid, .regWriteAddr,
      .regWriteData, .modeSetValid, .modeSetTo, .opMode, .spiErrorFlag, .spiErrorPulse, .spiErrorClear);
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   function automatic logic [15:0] par(input logic [15:0] v);
      return {v[15:1], ~^v[15:1]};
   endfunction : par
   task automatic step(input logic [15:0] w, input logic [6:0] m, input logic e, input logic [15:0] a);
      logic [15:0] got;
      int n0;
      n0 = pulseCnt;
      scd_spi_master_inst.xfer(w, 16, got);
      `CHK(got, par(expAns))
      `CHK(opMode, m)
      `CHK(pulseCnt != n0, e)
      expAns = a;
   endtask : step
   task automatic setMode(input logic [6:0] m);
      modeSetTo = scd_pkg::scd_mode_e'(m);
      modeSetValid = 1'h1;
      @(posedge sys_clk) #1 modeSetValid = 1'h0;
   endtask : setMode
   task automatic endOfTest;
      $display("checked %0d errCount %0d", checked, errCount);
      if (errCount == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : endOfTest
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      repeat (3) @(posedge sys_clk);
      #1 arst_n = 1'h1;
      repeat (3) @(posedge sys_clk);
      #1;
      foreach (rows[i]) begin
         step(par(rows[i].q), rows[i].m, rows[i].e, rows[i].a);
         `CHK(lastW, rows[i].d)
      end
      // A 15-bit frame must be refused and answered with the invalid bit
      nPulse = pulseCnt;
      scd_spi_master_inst.xfer(par(16'h1410), 15, gotShort);
      `CHK(pulseCnt != nPulse, 1'h1)
      `CHK(opMode, 7'h08)
      expAns = 16'hb456;
      setMode(7'h10);
      step(par(16'h04aa), 7'h10, 1'h1, 16'hb456);
      step(par(16'h012a), 7'h10, 1'h0, 16'ha23c);
      setMode(7'h40);
      step(par(16'h04aa), 7'h40, 1'h1, 16'hb456);
      setMode(7'h02);
      step(par(16'h1880), 7'h04, 1'h0, 16'h3456);
      step(par(16'h1140), 7'h20, 1'h0, 16'h3456);
      step(par(16'h4402) ^ 16'h1, 7'h20, 1'h1, 16'hb456);
      parEn = 1'h0;
      step(par(16'h4402) ^ 16'h1, 7'h20, 1'h0, 16'h3456);
      step(par(16'h1410) ^ 16'h1, 7'h20, 1'h1, 16'hb456);
      `CHK(spiErrorFlag, 1'h1)
      spiErrorClear = 1'h1;
      @(posedge sys_clk) #1 spiErrorClear = 1'h0;
      @(posedge sys_clk) #1;
      `CHK(spiErrorFlag, 1'h0)
      // Error arriving while clear is held: set wins for one cycle, then clear takes it
      spiErrorClear = 1'h1;
      step(par(16'h1410) ^ 16'h1, 7'h20, 1'h1, 16'hb456);
      `CHK(spiErrorFlag, 1'h0)
      spiErrorClear = 1'h0;
      arst_n = 1'h0;
      repeat (3) @(posedge sys_clk);
      `CHK(opMode, 7'h01)
      #1 arst_n = 1'h1;
      expAns = st;
      repeat (3) @(posedge sys_clk);
      #1;
      step(par(16'h1410), 7'h01, 1'h0, 16'h3456);
      endOfTest;
   end
endmodule : tb
